// file: include/ctsr_pkg.sv
// Package with register numbers, field positions and reset values
package ctsr_pkg;
   // Special-register numbers
   localparam logic [7:0] CTSR_REG_ADDR  = 8'h04;
   localparam logic [7:0] CTSR_REG_DATA  = 8'h05;
   localparam logic [7:0] CTSR_REG_CTRL  = 8'h06;
   localparam logic [7:0] CTSR_REG_GUARD = 8'h07;
   localparam logic [7:0] CTSR_REG_TCNT  = 8'h08;
   localparam logic [7:0] CTSR_REG_TRLD  = 8'h09;
   localparam logic [7:0] CTSR_REG_PC0   = 8'h0a;
   // Transaction control fields
   localparam int CTSR_CC_OPC_LSB = 24;
   localparam int CTSR_CC_CNT_LSB = 16;
   localparam int CTSR_CC_RNW     = 15;
   localparam int CTSR_CC_MUL     = 14;
   localparam int CTSR_CC_SET     = 13;
   localparam int CTSR_CC_LCK     = 12;
   localparam int CTSR_CC_TF      = 10;
   localparam int CTSR_CC_REG_LSB = 2;
   localparam int CTSR_CC_NN      = 1;
   localparam int CTSR_CC_CV      = 0;
   localparam logic [31:0] CTSR_CC_WMASK = 32'hffff_f7ff;
   // Timer reload fields
   localparam int CTSR_TR_MISS = 26;
   localparam int CTSR_TR_FLAG = 25;
   localparam int CTSR_TR_IE   = 24;
   localparam int CTSR_TW      = 24;
   localparam int CTSR_BANKS   = 16;
   // Reset values
   localparam logic [31:0] CTSR_RST_WORD  = 32'h0000_0000;
   localparam logic [23:0] CTSR_RST_TIMER = 24'h00_0000;
   localparam logic [15:0] CTSR_RST_GUARD = 16'h0000;
endpackage : ctsr_pkg

// file: rtl/ctsr_regs.sv
// Channel, bank-guard, timer and decode-pc special registers
`timescale 1ns/1ps
module ctsr_regs
   import ctsr_pkg::*;
#(
   parameter int TW = CTSR_TW
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Special-register move port
   input  wire logic        sr_wr,
   input  wire logic [7:0]  sr_num,
   input  wire logic [31:0] sr_wdata,
   output logic [31:0]      sr_rdata,
   // Processor status inputs
   input  wire logic        supervisor_flag,
   input  wire logic        mask_all_traps,
   input  wire logic        freeze_clear,
   input  wire logic        trap_taken,
   // Channel transaction capture
   input  wire logic        ch_xfer,
   input  wire logic [31:0] ch_address,
   input  wire logic [31:0] ch_store_data,
   input  wire logic [7:0]  ch_opcode_bits,
   input  wire logic [7:0]  ch_remaining,
   input  wire logic        ch_is_load,
   input  wire logic        ch_is_coproc,
   input  wire logic        ch_multiple_partial,
   input  wire logic        ch_load_set,
   input  wire logic        ch_lock_op,
   input  wire logic [7:0]  ch_reg_num,
   input  wire logic        ch_done,
   input  wire logic        data_error_in,
   input  wire logic        load_overlap_write,
   // Register-file access check
   input  wire logic        gr_access,
   input  wire logic [7:0]  gr_abs_num,
   // Decode stage
   input  wire logic        dec_valid,
   input  wire logic [31:0] dec_addr,
   // Results
   output logic            freeze_hold,
   output logic            protection_trap,
   output logic            data_access_trap,
   output logic            coproc_trap,
   output logic            timer_irq
);

   logic [31:0]   addr_q;
   logic [31:0]   data_q;
   logic [31:0]   ctrl_q;
   logic [15:0]   guard_q;
   logic [TW-1:0] count_q;
   logic [TW-1:0] reload_q;
   logic          flag_q;
   logic          miss_q;
   logic          ie_q;
   logic          coproc_q;
   logic [29:0]   pc0_q;
   logic          freeze_q;
   logic          expire;
   logic          capture;
   logic [15:0]   bank_hit;

   assign capture = ch_xfer && !freeze_q;
   assign freeze_hold = freeze_q;

   // Freeze bit: set on trap entry, cleared by status write
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         freeze_q <= 1'b0;
      end else if (trap_taken) begin
         freeze_q <= 1'b1;
      end else if (freeze_clear) begin
         freeze_q <= 1'b0;
      end
   end

   // Channel address register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         addr_q <= CTSR_RST_WORD;
      end else if (sr_wr && sr_num == CTSR_REG_ADDR) begin
         addr_q <= sr_wdata;
      end else if (capture) begin
         addr_q <= ch_address;
      end
   end

   // Channel data register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         data_q <= CTSR_RST_WORD;
      end else if (sr_wr && sr_num == CTSR_REG_DATA) begin
         data_q <= sr_wdata;
      end else if (capture) begin
         data_q <= ch_store_data;  // Meaningless for loads
      end
   end

   // Channel control register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q   <= CTSR_RST_WORD;
         coproc_q <= 1'b0;
      end else begin
         if (sr_wr && sr_num == CTSR_REG_CTRL) begin
            ctrl_q <= sr_wdata & CTSR_CC_WMASK;
         end else if (capture) begin
            ctrl_q[31:CTSR_CC_OPC_LSB] <= ch_opcode_bits;
            ctrl_q[23:CTSR_CC_CNT_LSB] <= ch_remaining;
            ctrl_q[CTSR_CC_RNW] <= ch_is_load;
            ctrl_q[CTSR_CC_MUL] <= ch_multiple_partial;
            ctrl_q[CTSR_CC_SET] <= ch_load_set && ch_is_load;
            ctrl_q[CTSR_CC_LCK] <= ch_lock_op;
            ctrl_q[11]          <= 1'b0;
            ctrl_q[CTSR_CC_TF]  <= data_error_in;
            ctrl_q[9:CTSR_CC_REG_LSB] <= ch_reg_num;
            ctrl_q[CTSR_CC_NN] <= 1'b0;
            ctrl_q[CTSR_CC_CV] <= !ch_done;
            coproc_q <= ch_is_coproc;
         end else begin
            if (data_error_in && ctrl_q[CTSR_CC_CV] && !freeze_q) begin
               ctrl_q[CTSR_CC_TF] <= 1'b1;
            end
            if (load_overlap_write && ctrl_q[CTSR_CC_CV] && ctrl_q[CTSR_CC_RNW]) begin
               ctrl_q[CTSR_CC_NN] <= 1'b1;
            end
            if (ch_done && !freeze_q) begin
               ctrl_q[CTSR_CC_CV] <= 1'b0;
            end
         end
      end
   end

   assign data_access_trap = ctrl_q[CTSR_CC_TF] && !coproc_q;
   assign coproc_trap      = ctrl_q[CTSR_CC_TF] && coproc_q;

   // Bank-guard register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         guard_q <= CTSR_RST_GUARD;
      end else if (sr_wr && sr_num == CTSR_REG_GUARD) begin
         guard_q <= sr_wdata[15:0];
      end
   end

   genvar gb;
   generate
      for (gb = 0; gb < CTSR_BANKS; gb++) begin : g_bank
         assign bank_hit[gb] = guard_q[gb] && (gr_abs_num[7:4] == 4'(gb));
      end
   endgenerate

   assign protection_trap = gr_access && !supervisor_flag && (|bank_hit);

   // expiry at the reload edge, after a full cycle at zero
   assign expire = (count_q == '0) && !(sr_wr && sr_num == CTSR_REG_TCNT);

   // Countdown and reload
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= CTSR_RST_TIMER[TW-1:0];
      end else if (sr_wr && sr_num == CTSR_REG_TCNT) begin
         count_q <= sr_wdata[TW-1:0];
      end else begin
         if (count_q == '0) begin
            count_q <= reload_q;  // Flag sets on this same edge
         end else begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   // Reload register with enable and status flags
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         reload_q <= CTSR_RST_TIMER[TW-1:0];
         ie_q     <= 1'b0;
         flag_q   <= 1'b0;
         miss_q   <= 1'b0;
      end else begin
         if (sr_wr && sr_num == CTSR_REG_TRLD) begin
            reload_q <= sr_wdata[TW-1:0];
            ie_q     <= sr_wdata[CTSR_TR_IE];
            flag_q   <= sr_wdata[CTSR_TR_FLAG];
            miss_q   <= sr_wdata[CTSR_TR_MISS];
         end
         // flag on every expiry, set wins
         if (expire) begin
            flag_q <= 1'b1;
            if (flag_q) begin
               miss_q <= 1'b1;
            end
         end
      end
   end

   assign timer_irq = flag_q && ie_q && !mask_all_traps;

   // Decode-stage program counter
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pc0_q <= 30'h0000_0000;
      end else if (sr_wr && sr_num == CTSR_REG_PC0) begin
         pc0_q <= sr_wdata[31:2];
      end else if (dec_valid && !freeze_q) begin
         pc0_q <= dec_addr[31:2];
      end
   end

   // Read mux; reserved bits zero
   always_comb begin
      sr_rdata = 32'h0000_0000;
      case (sr_num)
         CTSR_REG_ADDR:  sr_rdata = addr_q;
         CTSR_REG_DATA:  sr_rdata = data_q;
         CTSR_REG_CTRL:  sr_rdata = ctrl_q & CTSR_CC_WMASK;
         CTSR_REG_GUARD: sr_rdata = {16'h0000, guard_q};
         CTSR_REG_TCNT:  sr_rdata = 32'(count_q);
         CTSR_REG_TRLD:  sr_rdata = {5'h00, miss_q, flag_q, ie_q, 24'(reload_q)};
         CTSR_REG_PC0:   sr_rdata = {pc0_q, 2'b00};
         default:        sr_rdata = 32'h0000_0000;
      endcase
   end

endmodule : ctsr_regs

// file: tb/ctsr_regs_assertions.sv
// Port-level checker for the special-register block
`timescale 1ns/1ps
module ctsr_chk
   import ctsr_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        sr_wr,
   input wire logic [7:0]  sr_num,
   input wire logic [31:0] sr_wdata,
   input wire logic [31:0] sr_rdata,
   input wire logic        supervisor_flag,
   input wire logic        mask_all_traps,
   input wire logic        trap_taken,
   input wire logic        gr_access,
   input wire logic [7:0]  gr_abs_num,
   input wire logic        freeze_hold,
   input wire logic        protection_trap,
   input wire logic        data_access_trap,
   input wire logic        coproc_trap,
   input wire logic        timer_irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_trap_freezes: assert property (trap_taken |=> freeze_hold)
      else $error("freeze not set after trap");
   a_super_exempt: assert property (supervisor_flag |-> !protection_trap)
      else $error("supervisor access trapped");
   a_guard_trap: assert property ((gr_access && !supervisor_flag && sr_num == CTSR_REG_GUARD)
      |-> protection_trap == sr_rdata[gr_abs_num[7:4]]) else $error("guard trap wrong");
   a_irq_masked: assert property (mask_all_traps |-> !timer_irq)
      else $error("timer irq while masked");
   a_irq_raised: assert property ((sr_num == CTSR_REG_TRLD && sr_rdata[25:24] == 2'h3
      && !mask_all_traps) |-> timer_irq) else $error("timer irq missing");
   a_fault_trap: assert property ((sr_num == CTSR_REG_CTRL)
      |-> (data_access_trap || coproc_trap) == sr_rdata[10]) else $error("fault trap wrong");
   a_guard_write: assert property ((sr_wr && sr_num == CTSR_REG_GUARD) ##1
      (sr_num == CTSR_REG_GUARD) |-> sr_rdata == ($past(sr_wdata) & 32'h0000_ffff))
      else $error("guard write lost");
   a_pc_frozen: assert property ((freeze_hold && !sr_wr && sr_num == CTSR_REG_PC0) ##1
      (sr_num == CTSR_REG_PC0) |-> $stable(sr_rdata)) else $error("pc moved while frozen");
   // Main scenarios reached
   cover property (protection_trap);
   cover property (timer_irq);
   cover property (trap_taken ##1 freeze_hold);
endmodule : ctsr_chk

// file: tb/tb_ctsr_regs.sv
// Self-checking bench for the special-register block
`timescale 1ns/1ps
module tb_ctsr_regs;
   import ctsr_pkg::*;
   logic mclk, rst_b, sr_wr, supervisor_flag, mask_all_traps, freeze_clear, trap_taken;
   logic ch_xfer, ch_is_load, ch_is_coproc, ch_multiple_partial, ch_load_set, ch_lock_op;
   logic ch_done, data_error_in, load_overlap_write, gr_access, dec_valid;
   logic freeze_hold, protection_trap, data_access_trap, coproc_trap, timer_irq;
   logic [7:0]  sr_num, ch_opcode_bits, ch_remaining, ch_reg_num, gr_abs_num;
   logic [31:0] sr_wdata, sr_rdata, ch_address, ch_store_data, dec_addr;
   int          err_total, checks;
   ctsr_regs dut_u (.*);
   // Free-running clock
   initial begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] n, input logic [31:0] d);
      @(posedge mclk);
      sr_wr <= 1'b1;
      sr_num <= n;
      sr_wdata <= d;
      @(posedge mclk);
      sr_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] n, input logic [31:0] e);
      @(posedge mclk);
      sr_num <= n;
      #1 chk($sformatf("reg %h", n), e, sr_rdata);
   endtask : rd
   task automatic t_reset;
      for (int n = 4; n < 11; n++)
         if (n != 8 && n != 9) rd(8'(n), 32'h0);
      wr(8'h0b, 32'hffff_ffff);
      rd(8'h0b, 32'h0);
   endtask : t_reset
   task automatic t_guard;
      wr(CTSR_REG_GUARD, 32'hffff_0800);
      rd(CTSR_REG_GUARD, 32'h0000_0800);
      @(posedge mclk);
      gr_access <= 1'b1;
      gr_abs_num <= 8'hb5;
      #1 chk("prot", 32'h1, protection_trap);
      @(posedge mclk);
      gr_abs_num <= 8'ha5;
      #1 chk("prot", 32'h0, protection_trap);
      @(posedge mclk);
      gr_abs_num <= 8'hb5;
      supervisor_flag <= 1'b1;
      #1 chk("prot", 32'h0, protection_trap);
      @(posedge mclk);
      gr_access <= 1'b0;
      supervisor_flag <= 1'b0;
   endtask : t_guard
   // One transfer with the given kind flags
   task automatic xfer(input logic [31:0] a, input logic [7:0] op, rem, rg,
                       input logic [7:0] f);
      @(posedge mclk);
      {ch_is_load, ch_is_coproc, ch_multiple_partial, ch_load_set} <= f[7:4];
      {ch_lock_op, ch_done, data_error_in} <= f[2:0];
      {ch_xfer, ch_address, ch_store_data} <= {1'b1, a, ~a};
      {ch_opcode_bits, ch_remaining, ch_reg_num} <= {op, rem, rg};
      @(posedge mclk);
      ch_xfer <= 1'b0;
   endtask : xfer
   task automatic t_channel;
      xfer(32'h8000_1234, 8'h5a, 8'h1c, 8'h83, 8'h24);
      rd(CTSR_REG_ADDR, 32'h8000_1234);
      rd(CTSR_REG_DATA, 32'h7fff_edcb);
      rd(CTSR_REG_CTRL, 32'h5a1c_520d);
      xfer(32'h0000_0040, 8'h01, 8'h00, 8'h40, 8'h93);
      rd(CTSR_REG_CTRL, 32'h0100_a500);
      chk("dtrap", 32'h1, {coproc_trap, data_access_trap});
      wr(CTSR_REG_CTRL, 32'h0);
      rd(CTSR_REG_CTRL, 32'h0);
      xfer(32'h0bad_c0de, 8'h02, 8'h00, 8'h10, 8'h43);
      rd(CTSR_REG_ADDR, 32'h0bad_c0de);
      chk("ctrap", 32'h2, {coproc_trap, data_access_trap});
      data_error_in <= 1'b0;
      xfer(32'h0000_0100, 8'h03, 8'h00, 8'h20, 8'h80);
      @(posedge mclk);
      load_overlap_write <= 1'b1;
      @(posedge mclk);
      load_overlap_write <= 1'b0;
      rd(CTSR_REG_CTRL, 32'h0300_8083);
   endtask : t_channel
   task automatic t_freeze;
      @(posedge mclk);
      {dec_valid, dec_addr} <= {1'b1, 32'h0000_4567};
      @(posedge mclk);
      {dec_valid, trap_taken} <= 2'h1;
      @(posedge mclk);
      trap_taken <= 1'b0;
      #1 chk("freeze", 32'h1, freeze_hold);
      rd(CTSR_REG_PC0, 32'h0000_4564);
      @(posedge mclk);
      {dec_valid, dec_addr, ch_xfer, ch_address} <= {1'b1, 32'h0000_9998, 1'b1, 32'h0};
      @(posedge mclk);
      {dec_valid, ch_xfer} <= 2'h0;
      rd(CTSR_REG_PC0, 32'h0000_4564);
      rd(CTSR_REG_ADDR, 32'h0000_0100);
      @(posedge mclk);
      freeze_clear <= 1'b1;
      @(posedge mclk);
      freeze_clear <= 1'b0;
      #1 chk("freeze", 32'h0, freeze_hold);
   endtask : t_freeze
   task automatic t_timer;
      wr(CTSR_REG_TCNT, 32'h0000_001c);
      wr(CTSR_REG_TRLD, 32'h0100_0003);
      repeat (26) @(posedge mclk);
      sr_num <= CTSR_REG_TRLD;
      #1 chk("flag", 32'h0, sr_rdata[25]);
      @(posedge mclk);
      #1 chk("irq", 32'h3, {sr_rdata[25], timer_irq});
      repeat (3) @(posedge mclk);
      #1 chk("miss", 32'h0, sr_rdata[26]);
      @(posedge mclk);
      #1 chk("miss", 32'h1, sr_rdata[26]);
      @(posedge mclk);
      mask_all_traps <= 1'b1;
      #1 chk("irq", 32'h0, timer_irq);
   endtask : t_timer
   task automatic test_done;
      if (err_total == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   // Reset, then each scenario in turn
   initial begin
      {sr_wr, supervisor_flag, mask_all_traps, freeze_clear, trap_taken, ch_xfer} = '0;
      {ch_is_load, ch_is_coproc, ch_multiple_partial, ch_load_set, ch_lock_op} = '0;
      {ch_done, data_error_in, load_overlap_write, gr_access, dec_valid} = '0;
      {sr_num, ch_opcode_bits, ch_remaining, ch_reg_num, gr_abs_num} = '0;
      {sr_wdata, ch_address, ch_store_data, dec_addr} = '0;
      err_total = 0;
      checks = 0;
      rst_b = 1'b0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_guard();
      t_channel();
      t_freeze();
      t_timer();
      test_done();
   end
endmodule : tb_ctsr_regs
bind ctsr_regs ctsr_chk chk_u (.*);
